//--- shared/buck_ctrl_pkg.sv
// Constants, timing counts and state types for the buck mode and supervisor control
`default_nettype none
package buck_ctrl_pkg;
  // ----------------------------------------------------------------
  // Converter set
  // ----------------------------------------------------------------
  localparam int BUCK_COUNT = 3;
  localparam int BUCK_C = 2;

  // ----------------------------------------------------------------
  // Mode select register
  // ----------------------------------------------------------------
  localparam logic [7:0] MODE_SELECT_ADDR = 8'h47;
  localparam logic [7:0] MODE_SELECT_RESET = 8'h00;
  localparam logic [7:0] MODE_SELECT_MASK = 8'h77;
  localparam logic [7:0] READ_IDLE = 8'h00;
  localparam int FORCE_PWM_LSB = 0;
  localparam int PIN_SEL_LSB = 4;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 8;
  localparam int BURST_MAX_NS = 7000;
  localparam int BURST_MAX_CYC = BURST_MAX_NS / CLK_PERIOD_NS;
  localparam int BIAS_DELAY_NS = 170000;
  localparam int BIAS_DELAY_CYC = (BIAS_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SOFT_START_NS = 250000;
  localparam int SOFT_START_CYC = (SOFT_START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DEAD_TIME_NS = 16;
  localparam int DEAD_TIME_CYC = (DEAD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PWM_PERIOD_CYC = 100;
  localparam int TIMER_W = 16;
  localparam int BURST_W = 10;
  localparam int DEAD_W = 4;

  // ----------------------------------------------------------------
  // State types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_OFF = 2'b00,
    ST_BIAS = 2'b01,
    ST_SOFT = 2'b10,
    ST_RUN = 2'b11
  } seq_state_type;

  typedef enum logic [1:0] {
    SW_IDLE = 2'b00,
    SW_HIGH = 2'b01,
    SW_DEAD = 2'b10,
    SW_LOW = 2'b11
  } switch_state_type;
endpackage : buck_ctrl_pkg
`default_nettype wire

//--- shared/phase_clk_if.sv
// Cycle start strobes from the phase clock to the converter control
`default_nettype none
interface phase_clk_if #(
  parameter int N = 3
);
  logic [N-1:0] cycle_start;
  modport gen (output cycle_start);
  modport user (input cycle_start);
endinterface : phase_clk_if
`default_nettype wire

//--- logic/phase_clock.sv
// Staggered switching cycle strobes for the three converters
`default_nettype none
module phase_clock import buck_ctrl_pkg::*; #(
  parameter int PERIOD_CYC = PWM_PERIOD_CYC
) (
  input wire logic i_clk,   // System clock
  input wire logic i_rst_n, // Synchronised reset, active low
  phase_clk_if.gen ph       // Cycle start strobes
);
  localparam int CNT_W = $clog2(PERIOD_CYC);
  localparam int QUARTER_I = PERIOD_CYC / 4;
  localparam int HALF_I = PERIOD_CYC / 2;
  localparam logic [CNT_W-1:0] LAST = CNT_W'(PERIOD_CYC - 1);
  localparam logic [CNT_W-1:0] QUARTER = CNT_W'(QUARTER_I);
  localparam logic [CNT_W-1:0] HALF = CNT_W'(HALF_I);

  logic [CNT_W-1:0] phase_cnt_reg;

  // ----------------------------------------------------------------
  // Master period counter, converter a at phase zero
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      phase_cnt_reg <= '0;
    end else if (phase_cnt_reg == LAST) begin
      phase_cnt_reg <= '0;
    end else begin
      phase_cnt_reg <= phase_cnt_reg + 1'b1;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ph.cycle_start <= '0;
    end else begin
      ph.cycle_start <= {phase_cnt_reg == HALF, phase_cnt_reg == QUARTER,
                         phase_cnt_reg == '0};
    end
  end

  phase_b_offset_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    ph.cycle_start[0] |-> ##QUARTER_I ph.cycle_start[1])
    else $error("converter b strobe not a quarter period after a");
  phase_c_offset_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    ph.cycle_start[0] |-> ##HALF_I ph.cycle_start[2])
    else $error("converter c strobe not half a period after a");
endmodule : phase_clock
`default_nettype wire

//--- logic/buck_mode_and_supervisor_control.sv
// Mode selection, PFM burst control, sequencing and supervision of three buck converters
`default_nettype none
module buck_mode_and_supervisor_control import buck_ctrl_pkg::*; #(
  parameter int BIAS_CYC = BIAS_DELAY_CYC,
  parameter int SOFT_CYC = SOFT_START_CYC,
  parameter int PERIOD_CYC = PWM_PERIOD_CYC,
  parameter logic [7:0] MODE_RESET = MODE_SELECT_RESET
) (
  input wire logic i_sys_clk,                   // System clock, 125 MHz
  input wire logic i_arst_n,                    // Asynchronous reset, active low
  input wire logic [7:0] i_reg_addr,            // Register address
  input wire logic i_reg_wr,                    // Register write strobe
  input wire logic i_reg_rd,                    // Register read strobe
  input wire logic [7:0] i_reg_wdata,           // Register write data
  output logic [7:0] o_reg_rdata,               // Register read data
  input wire logic i_mode_pin,                  // External mode pin
  input wire logic i_pin_polarity_invert,       // Mode pin polarity invert
  input wire logic [2:0] i_enable,              // Converter enable commands
  input wire logic i_normal_state,              // Device in normal state
  input wire logic i_supply_sequence_state,     // Device in supply sequence state
  input wire logic [2:0] i_ripple_near_zero,    // Ripple current near zero
  input wire logic [2:0] i_below_target,        // Output below PFM target
  input wire logic [2:0] i_below_pfm_limit,     // Output 3% under PFM target
  input wire logic [2:0] i_ramp_at_error,       // Ramp reached error level
  input wire logic [2:0] i_low_headroom,        // Input headroom too small
  input wire logic [2:0] i_below_pg_threshold,  // Output under 90% of setting
  input wire logic [2:0] i_vout_transition,     // Output moving between settings
  input wire logic i_battery_tracking,          // Converter c in battery tracking
  output logic [2:0] o_pwm_mode,                // Converter in PWM operation
  output logic [2:0] o_power_stage_en,          // Power stage may switch
  output logic [2:0] o_high_side_on,            // High side switch drive
  output logic [2:0] o_low_side_on,             // Low side switch drive
  output logic [2:0] o_soft_start,              // Soft start in progress
  output logic [2:0] o_output_ready,            // Converter regulating
  output logic [2:0] o_discharge_on,            // Output discharge switch
  output logic [2:0] o_power_not_good           // Output low flag
);
  localparam logic [TIMER_W-1:0] BIAS_LAST = TIMER_W'(BIAS_CYC - 1);
  localparam logic [TIMER_W-1:0] SOFT_LAST = TIMER_W'(SOFT_CYC - 1);
  localparam logic [BURST_W-1:0] BURST_LIMIT = BURST_W'(BURST_MAX_CYC);
  localparam logic [DEAD_W-1:0] DEAD_LAST = DEAD_W'(DEAD_TIME_CYC - 1);

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic rst_meta_reg;
  logic rst_n;

  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rst_meta_reg <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n <= rst_meta_reg;
    end
  end
  default clocking main_cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!rst_n);

  // ----------------------------------------------------------------
  // Mode request decode
  // ----------------------------------------------------------------
  function automatic logic pwm_requested(input logic [7:0] sel, input int ch,
                                         input logic pin, input logic inv);
    if (sel[PIN_SEL_LSB + ch]) begin
      pwm_requested = pin ^ inv;
    end else begin
      pwm_requested = sel[FORCE_PWM_LSB + ch];
    end
  endfunction : pwm_requested

  logic [7:0] mode_select_reg;
  logic [2:0] forced_pwm;
  logic [2:0] switch_allowed;
  seq_state_type seq_state_reg [BUCK_COUNT];
  logic [TIMER_W-1:0] seq_timer_reg [BUCK_COUNT];
  switch_state_type sw_state_reg [BUCK_COUNT];
  logic [DEAD_W-1:0] dead_cnt_reg [BUCK_COUNT];
  logic [BURST_W-1:0] burst_cnt_reg [BUCK_COUNT];
  logic [2:0] pfm_reg;
  logic [2:0] burst_on_reg;
  logic discharge_allowed;

  phase_clk_if #(.N(BUCK_COUNT)) phase_bus ();
  phase_clock #(.PERIOD_CYC(PERIOD_CYC)) u_phase_clock (
    .i_clk(i_sys_clk),
    .i_rst_n(rst_n),
    .ph(phase_bus.gen)
  );

  always_comb begin
    forced_pwm = '0;
    switch_allowed = '0;
    for (int ch = 0; ch < BUCK_COUNT; ch++) begin
      forced_pwm[ch] = pwm_requested(mode_select_reg, ch, i_mode_pin, i_pin_polarity_invert);
      switch_allowed[ch] = (seq_state_reg[ch] == ST_SOFT || seq_state_reg[ch] == ST_RUN) &&
                           (!pfm_reg[ch] || burst_on_reg[ch]);
    end
  end

  assign discharge_allowed = i_normal_state | i_supply_sequence_state;

  // ----------------------------------------------------------------
  // Mode select register
  // ----------------------------------------------------------------
  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_select_reg <= MODE_RESET & MODE_SELECT_MASK;
    end else if (i_reg_wr && i_reg_addr == MODE_SELECT_ADDR) begin
      mode_select_reg <= i_reg_wdata & MODE_SELECT_MASK;
    end
  end

  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_reg_rdata <= READ_IDLE;
    end else if (i_reg_rd) begin
      o_reg_rdata <= (i_reg_addr == MODE_SELECT_ADDR) ? mode_select_reg : READ_IDLE;
    end
  end

  // ----------------------------------------------------------------
  // Enable sequencing: bias delay, soft start, run
  // ----------------------------------------------------------------
  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int ch = 0; ch < BUCK_COUNT; ch++) begin
        seq_state_reg[ch] <= ST_OFF;
        seq_timer_reg[ch] <= '0;
      end
    end else begin
      for (int ch = 0; ch < BUCK_COUNT; ch++) begin
        case (seq_state_reg[ch])
          ST_OFF: begin
            seq_timer_reg[ch] <= '0;
            if (i_enable[ch]) begin
              seq_state_reg[ch] <= ST_BIAS;
            end
          end
          ST_BIAS: begin
            if (seq_timer_reg[ch] == BIAS_LAST) begin
              seq_state_reg[ch] <= ST_SOFT;
              seq_timer_reg[ch] <= '0;
            end else begin
              seq_timer_reg[ch] <= seq_timer_reg[ch] + 1'b1;
            end
          end
          ST_SOFT: begin
            if (seq_timer_reg[ch] == SOFT_LAST) begin
              seq_state_reg[ch] <= ST_RUN;
              seq_timer_reg[ch] <= '0;
            end else begin
              seq_timer_reg[ch] <= seq_timer_reg[ch] + 1'b1;
            end
          end
          ST_RUN: begin
            seq_timer_reg[ch] <= '0;
          end
          default: begin
            seq_state_reg[ch] <= ST_OFF;
          end
        endcase
        if (!i_enable[ch]) begin
          seq_state_reg[ch] <= ST_OFF;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // PWM / PFM mode and burst regulation
  // ----------------------------------------------------------------
  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pfm_reg <= '0;
    end else begin
      for (int ch = 0; ch < BUCK_COUNT; ch++) begin
        if (seq_state_reg[ch] != ST_RUN || forced_pwm[ch]) begin
          pfm_reg[ch] <= 1'b0;
        end else if (!pfm_reg[ch]) begin
          pfm_reg[ch] <= i_ripple_near_zero[ch];
        end else if (burst_cnt_reg[ch] >= BURST_LIMIT || i_below_pfm_limit[ch]) begin
          pfm_reg[ch] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      burst_on_reg <= '0;
      for (int ch = 0; ch < BUCK_COUNT; ch++) begin
        burst_cnt_reg[ch] <= '0;
      end
    end else begin
      for (int ch = 0; ch < BUCK_COUNT; ch++) begin
        burst_on_reg[ch] <= pfm_reg[ch] && i_below_target[ch];
        if (!burst_on_reg[ch] || !pfm_reg[ch]) begin
          burst_cnt_reg[ch] <= '0;
        end else if (burst_cnt_reg[ch] < BURST_LIMIT) begin
          burst_cnt_reg[ch] <= burst_cnt_reg[ch] + 1'b1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Switch sequencing, dead time before low side turn-on and full duty
  // ----------------------------------------------------------------
  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int ch = 0; ch < BUCK_COUNT; ch++) begin
        sw_state_reg[ch] <= SW_IDLE;
        dead_cnt_reg[ch] <= '0;
      end
    end else begin
      for (int ch = 0; ch < BUCK_COUNT; ch++) begin
        if (!switch_allowed[ch]) begin
          sw_state_reg[ch] <= SW_IDLE;
        end else begin
          case (sw_state_reg[ch])
            SW_IDLE, SW_LOW: begin
              if (phase_bus.cycle_start[ch]) begin
                sw_state_reg[ch] <= SW_HIGH;
              end
            end
            SW_HIGH: begin
              if (i_ramp_at_error[ch] && !i_low_headroom[ch]) begin
                sw_state_reg[ch] <= SW_DEAD;
                dead_cnt_reg[ch] <= '0;
              end
            end
            SW_DEAD: begin
              if (dead_cnt_reg[ch] == DEAD_LAST) begin
                sw_state_reg[ch] <= SW_LOW;
              end else begin
                dead_cnt_reg[ch] <= dead_cnt_reg[ch] + 1'b1;
              end
            end
            default: begin
              sw_state_reg[ch] <= SW_IDLE;
            end
          endcase
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Registered outputs: drive, status, discharge, power good
  // ----------------------------------------------------------------
  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_pwm_mode <= '0;
      o_power_stage_en <= '0;
      o_high_side_on <= '0;
      o_low_side_on <= '0;
      o_soft_start <= '0;
      o_output_ready <= '0;
    end else begin
      for (int ch = 0; ch < BUCK_COUNT; ch++) begin
        o_pwm_mode[ch] <= (seq_state_reg[ch] != ST_OFF) && !pfm_reg[ch];
        o_power_stage_en[ch] <= switch_allowed[ch];
        o_high_side_on[ch] <= sw_state_reg[ch] == SW_HIGH;
        o_low_side_on[ch] <= sw_state_reg[ch] == SW_LOW;
        o_soft_start[ch] <= seq_state_reg[ch] == ST_SOFT;
        o_output_ready[ch] <= seq_state_reg[ch] == ST_RUN;
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_discharge_on <= '0;
    end else begin
      for (int ch = 0; ch < BUCK_COUNT; ch++) begin
        o_discharge_on[ch] <= (seq_state_reg[ch] == ST_OFF) && discharge_allowed;
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_power_not_good <= '0;
    end else begin
      for (int ch = 0; ch < BUCK_COUNT; ch++) begin
        o_power_not_good[ch] <= (seq_state_reg[ch] == ST_RUN) && i_below_pg_threshold[ch] &&
                                !i_vout_transition[ch] &&
                                !(ch == BUCK_C && i_battery_tracking);
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks per converter
  // ----------------------------------------------------------------
  for (genvar ch = 0; ch < BUCK_COUNT; ch++) begin : g_chk
    force_bit_pwm_a: assert property (
      !mode_select_reg[PIN_SEL_LSB + ch] && mode_select_reg[FORCE_PWM_LSB + ch] &&
      !i_reg_wr && pfm_reg[ch] |=> !pfm_reg[ch] ##1 !pfm_reg[ch])
      else $error("forced PWM did not hold the converter out of PFM");
    pin_over_force_a: assert property (
      mode_select_reg[PIN_SEL_LSB + ch] && !mode_select_reg[FORCE_PWM_LSB + ch] &&
      (i_mode_pin != i_pin_polarity_invert) && pfm_reg[ch] |=> !pfm_reg[ch])
      else $error("mode pin PWM request ignored");
    pin_low_auto_a: assert property (
      mode_select_reg[PIN_SEL_LSB + ch] && mode_select_reg[FORCE_PWM_LSB + ch] &&
      !i_pin_polarity_invert && !i_mode_pin && seq_state_reg[ch] == ST_RUN &&
      !pfm_reg[ch] && i_ripple_near_zero[ch] |=> pfm_reg[ch])
      else $error("mode pin low did not allow PFM");
    pfm_entry_a: assert property (
      seq_state_reg[ch] == ST_RUN && !forced_pwm[ch] && !pfm_reg[ch] &&
      i_ripple_near_zero[ch] |=> pfm_reg[ch])
      else $error("PFM not entered at low ripple");
    burst_follows_a: assert property (
      seq_state_reg[ch] == ST_RUN && i_enable[ch] && pfm_reg[ch] && i_below_target[ch] |=>
      burst_on_reg[ch] ##1 o_power_stage_en[ch])
      else $error("burst not started below target");
    burst_limit_a: assert property (
      pfm_reg[ch] && burst_cnt_reg[ch] == BURST_LIMIT |=> !pfm_reg[ch])
      else $error("long burst did not fall back to PWM");
    pfm_droop_a: assert property (
      pfm_reg[ch] && i_below_pfm_limit[ch] |=> !pfm_reg[ch])
      else $error("droop did not fall back to PWM");
    cycle_high_a: assert property (
      switch_allowed[ch] && sw_state_reg[ch] == SW_LOW && phase_bus.cycle_start[ch] |=>
      sw_state_reg[ch] == SW_HIGH ##1 o_high_side_on[ch] && !o_low_side_on[ch])
      else $error("high side not turned on at cycle start");
    full_duty_a: assert property (
      switch_allowed[ch] && sw_state_reg[ch] == SW_HIGH && i_low_headroom[ch] |=>
      sw_state_reg[ch] == SW_HIGH)
      else $error("high side released with low headroom");
    bias_hold_a: assert property (
      seq_state_reg[ch] == ST_BIAS && seq_timer_reg[ch] != BIAS_LAST && i_enable[ch] |=>
      seq_state_reg[ch] == ST_BIAS)
      else $error("soft start began before the bias delay");
    discharge_off_a: assert property (
      !i_enable[ch] ##1 discharge_allowed |=> o_discharge_on[ch])
      else $error("disabled converter not discharged");
    pg_masked_a: assert property (
      o_power_not_good[ch] |-> $past(!i_vout_transition[ch]) && $past(i_below_pg_threshold[ch]))
      else $error("power good flagged while masked or in range");
  end

  pg_track_mask_a: assert property (
    i_battery_tracking |=> !o_power_not_good[BUCK_C])
    else $error("converter c power good not masked in tracking");
endmodule : buck_mode_and_supervisor_control
`default_nettype wire

//--- verif/buck_mode_and_supervisor_control_tb_top.sv
// Directed bench for the buck mode and supervisor control
`default_nettype none
module buck_mode_and_supervisor_control_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // Signals and design
  // ----------------------------------------------------------------
  localparam int BC = 8;
  localparam int SC = 12;
  logic clk = 1'h0, arst_n = 1'h0, wr = 1'h0, rd = 1'h0, pin = 1'h0, inv = 1'h0;
  logic nrm = 1'h1, sup = 1'h0, trk = 1'h0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
  logic [2:0] en = 3'h0, rip = 3'h0, blt = 3'h0, blim = 3'h0, ramp = 3'h0, hdr = 3'h0;
  logic [2:0] bpg = 3'h0, trans = 3'h0;
  logic [2:0] pwm, pse, hs, ls, ss, rdy, dis, png;
  int error_cnt = 0, comparisons = 0;
  always #4 clk = ~clk;
  buck_mode_and_supervisor_control #(.BIAS_CYC(BC), .SOFT_CYC(SC)) dut (
    .i_sys_clk(clk), .i_arst_n(arst_n), .i_reg_addr(addr), .i_reg_wr(wr), .i_reg_rd(rd),
    .i_reg_wdata(wdata), .o_reg_rdata(rdata), .i_mode_pin(pin), .i_pin_polarity_invert(inv),
    .i_enable(en), .i_normal_state(nrm), .i_supply_sequence_state(sup),
    .i_ripple_near_zero(rip), .i_below_target(blt), .i_below_pfm_limit(blim),
    .i_ramp_at_error(ramp), .i_low_headroom(hdr), .i_below_pg_threshold(bpg),
    .i_vout_transition(trans), .i_battery_tracking(trk), .o_pwm_mode(pwm),
    .o_power_stage_en(pse), .o_high_side_on(hs), .o_low_side_on(ls), .o_soft_start(ss),
    .o_output_ready(rdy), .o_discharge_on(dis), .o_power_not_good(png));
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk) {wr, addr, wdata} = {1'b1, a, d};
    @(negedge clk) wr = 0;
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk) {rd, addr} = {1'b1, a};
    @(negedge clk) rd = 0;
    @(negedge clk) d = rdata;
  endtask : rd_reg
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : wrap_up
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    wrap_up();
  end
  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    logic [7:0] d;
    logic [2:0] g, f, prv;
    int t[3];
    int bad;
    cyc(16);
    arst_n = 1;
    cyc(4);
    rd_reg(8'h47, d); chk("reset_value", d, 8'h00);
    chk("discharge_off_state", {5'h0, dis}, 8'h07);
    wr_reg(8'h47, 8'hff); rd_reg(8'h47, d); chk("spare_bits", d, 8'h77);
    wr_reg(8'h48, 8'h00); rd_reg(8'h47, d); chk("other_addr_write", d, 8'h77);
    rd_reg(8'h48, d); chk("other_addr_read", d, 8'h00);
    $display("test registers done");
    wr_reg(8'h47, 8'h00);
    @(negedge clk) en = 3'h7;
    cyc(BC + 1); chk("bias_wait", {5'h0, ss}, 8'h00);
    cyc(1); chk("soft_start", {5'h0, ss}, 8'h07);
    chk("discharge_open", {5'h0, dis}, 8'h00);
    cyc(SC - 1); chk("not_ready", {5'h0, rdy}, 8'h00);
    cyc(1); chk("ready", {5'h0, rdy}, 8'h07);
    $display("test sequencing done");
    rip = 3'h7;
    for (int i = 0; i < 16; i++) begin
      g = {i[1], i[0], ~i[0]};
      f = {i[0], ~i[1], i[1]};
      wr_reg(8'h47, {1'b0, g, 1'b0, f});
      {pin, inv} = {i[2], i[3]};
      cyc(5);
      chk("mode", {5'h0, pwm}, {5'h0, (g & {3{pin ^ inv}}) | (~g & f)});
    end
    {pin, inv} = 2'h0;
    $display("test mode select done");
    wr_reg(8'h47, 8'h00); cyc(5);
    {rip, blt} = {3'h0, 3'h1}; cyc(5);
    chk("burst_stage", {5'h0, pse}, 8'h01);
    cyc(buck_ctrl_pkg::BURST_MAX_CYC - 3); chk("burst_pfm", {5'h0, pwm}, 8'h00);
    cyc(1); chk("burst_limit", {5'h0, pwm}, 8'h01);
    {blt, rip} = {3'h0, 3'h7}; cyc(5);
    {rip, blim} = {3'h0, 3'h2}; cyc(5);
    chk("pfm_low_exit", {5'h0, pwm}, 8'h02);
    $display("test pfm exit done");
    wr_reg(8'h47, 8'h07); ramp = 3'h7; cyc(200);
    prv = hs;
    for (int n = 0; n < 100; n++) begin
      @(negedge clk);
      for (int k = 0; k < 3; k++) if (hs[k] && !prv[k]) t[k] = n;
      prv = hs;
    end
    chk("phase_b", 8'((t[1] - t[0] + 100) % 100), 8'h19);
    chk("phase_c", 8'((t[2] - t[0] + 100) % 100), 8'h32);
    hdr = 3'h7; cyc(120); bad = 0;
    repeat (100) begin
      @(negedge clk);
      if (hs !== 3'h7 || ls !== 3'h0) bad++;
    end
    chk("full_duty", 8'(bad), 8'h00);
    $display("test switching done");
    {bpg, trans, trk} = {3'h7, 3'h2, 1'b1}; cyc(4);
    chk("pg_masked", {5'h0, png}, 8'h01);
    {trans, trk} = 4'h0; cyc(4);
    chk("pg_flag", {5'h0, png}, 8'h07);
    $display("test power good done");
    {en, nrm, sup} = {3'h0, 1'b0, 1'b1}; cyc(4);
    chk("discharge_seq", {5'h0, dis}, 8'h07);
    $display("test discharge done");
    @(negedge clk) arst_n = 1'h0;
    cyc(2); arst_n = 1'h1; cyc(4);
    chk("release_discharge", {5'h0, dis}, 8'h07);
    rd_reg(8'h47, d); chk("reset_again", d, 8'h00);
    $display("test reset done");
    wrap_up();
  end
endmodule : buck_mode_and_supervisor_control_tb_top
`default_nettype wire
